/* inc/upr_pkg.sv */
`default_nettype none
package upr_pkg;
  // Immediate address map
  localparam logic [5:0] UPR_ADDR_ESCAPE   = 6'h2f;
  localparam logic [5:0] UPR_VENDOR_FIRST  = 6'h30;
  localparam logic [5:0] UPR_VENDOR_LAST   = 6'h3f;
  localparam logic [5:0] UPR_PWR_WRITE     = 6'h3d;
  localparam logic [5:0] UPR_PWR_SET       = 6'h3e;
  localparam logic [5:0] UPR_PWR_CLEAR     = 6'h3f;
  localparam logic [5:0] UPR_SCRATCH_WRITE = 6'h16;
  localparam logic [5:0] UPR_SCRATCH_SET   = 6'h17;
  localparam logic [5:0] UPR_SCRATCH_CLEAR = 6'h18;
  // Extended space: only the low part is implemented
  localparam logic [7:0] UPR_EXT_LAST      = 8'h3f;
  // Write, set and clear addresses of one group follow each other
  localparam logic [5:0] UPR_GROUP_SPAN    = 6'h02;

  // Power control fields
  localparam int         UPR_BIT_PIN_SEL    = 0;
  localparam int         UPR_BIT_BV_RISE    = 2;
  localparam int         UPR_BIT_BV_FALL    = 3;
  localparam logic [7:0] UPR_PWR_RESET      = 8'h00;
  localparam logic [7:0] UPR_PWR_RSVD_MASK  = 8'hf0;
  localparam logic [7:0] UPR_SCRATCH_RESET  = 8'h00;
  localparam logic [7:0] UPR_RDATA_NONE     = 8'h00;

  typedef enum logic [1:0] {
    UPR_OP_WRITE = 2'b00,
    UPR_OP_SET   = 2'b01,
    UPR_OP_CLEAR = 2'b11,
    UPR_OP_READ  = 2'b10
  } upr_op_e;
endpackage
`default_nettype wire

/* inc/upr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface upr_if;
  import upr_pkg::*;
  logic            req;
  upr_op_e         op;
  logic            ext;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic            ack;
  logic [7:0]      rdata;
  logic            alternate_interrupt_flag;
  modport phy  (input req, op, ext, addr, wdata, output ack, rdata, alternate_interrupt_flag);
  modport link (output req, op, ext, addr, wdata, input ack, rdata, alternate_interrupt_flag);
endinterface
`default_nettype wire

/* verilog/upr_phy.sv */
// What this block does
// - Escape address holds no data; extended access is selected by the bus ext flag
// - Vendor registers occupy immediate 30h to 3Fh
// - Extended 00h-3Fh alias onto immediate registers
// - Link avoids extended addresses 40h to FFh
// - Power control read 3D-3F, write/set/clear
// - Link never writes ones to bits 7-4 at vendor addresses 30h to 3Fh
// - Fall enable: BVALID fall sends alternate interrupt
// - Rise enable: BVALID rise sends alternate interrupt
// - Edge notices optional; link uses session comparator
// - Bit 0 picks reset input or power output
// - Link sets bit 0 for ganged power
`timescale 1ns/1ps
`default_nettype none
module upr_phy (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  upr_if.phy              bus,
  input  wire logic       bvalid_i,
  input  wire logic       pin_i,
  input  wire logic       power_on_i,
  output logic            pin_o,
  output logic            pin_oe_o,
  output logic            pin_reset_o,
  output logic [7:0]      power_control_o
);
  import upr_pkg::*;

  logic [7:0] power_control;
  logic [7:0] scratch;
  logic       bvalid_q;
  logic       alt_flag_q;
  logic [7:0] rdata_q;
  logic [5:0] imm_addr;
  logic       addr_ok;
  logic       is_escape;
  logic       in_vendor;
  logic       is_read;
  logic       is_modify;
  logic       pwr_hit;
  logic       pwr_rd;
  logic       scr_hit;
  logic       scr_rd;
  logic       bvalid_rise;
  logic       bvalid_fall;
  logic       notify;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // New value of a register byte for a write, set or clear
  function automatic logic [7:0] upr_apply(input logic [7:0] cur, input upr_op_e op,
                                           input logic [7:0] d);
    case (op)
      UPR_OP_WRITE: begin
        upr_apply = d;
      end
      UPR_OP_SET: begin
        upr_apply = cur | d;
      end
      UPR_OP_CLEAR: begin
        upr_apply = cur & ~d;
      end
      default: begin
        upr_apply = cur;
      end
    endcase
  endfunction

  // Write, set and clear each act only at their own address of a group
  function automatic logic upr_modify_hit(input upr_op_e op, input logic [5:0] a,
                                          input logic [5:0] wr_addr,
                                          input logic [5:0] set_addr,
                                          input logic [5:0] clr_addr);
    case (op)
      UPR_OP_WRITE: begin
        upr_modify_hit = (a == wr_addr);
      end
      UPR_OP_SET: begin
        upr_modify_hit = (a == set_addr);
      end
      UPR_OP_CLEAR: begin
        upr_modify_hit = (a == clr_addr);
      end
      default: begin
        upr_modify_hit = 1'b0;
      end
    endcase
  endfunction

  // Reads answer at any address of a group
  function automatic logic in_group(input logic [5:0] a, input logic [5:0] base);
    in_group = (a >= base) && (a <= base + UPR_GROUP_SPAN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Extended accesses fold onto the immediate map; above 3Fh nothing acts
  always_comb begin
    imm_addr  = bus.addr[5:0];
    is_escape = !bus.ext && (imm_addr == UPR_ADDR_ESCAPE);
    in_vendor = (imm_addr >= UPR_VENDOR_FIRST);
    if (bus.ext) begin
      addr_ok = (bus.addr <= UPR_EXT_LAST);
    end else begin
      addr_ok = !is_escape;
    end
  end

  // Qualifiers shared by both register groups
  always_comb begin
    is_read   = bus.req && addr_ok && (bus.op == UPR_OP_READ);
    is_modify = bus.req && addr_ok && (bus.op != UPR_OP_READ);
  end

  always_comb begin
    pwr_hit = is_modify && upr_modify_hit(bus.op, imm_addr,
                                          UPR_PWR_WRITE, UPR_PWR_SET, UPR_PWR_CLEAR);
    scr_hit = is_modify && upr_modify_hit(bus.op, imm_addr,
                                          UPR_SCRATCH_WRITE, UPR_SCRATCH_SET,
                                          UPR_SCRATCH_CLEAR);
    pwr_rd  = is_read && in_vendor && in_group(imm_addr, UPR_PWR_WRITE);
    scr_rd  = is_read && in_group(imm_addr, UPR_SCRATCH_WRITE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_control <= UPR_PWR_RESET;
    end else if (pwr_hit) begin
      power_control <= upr_apply(power_control, bus.op, bus.wdata);
    end
  end

  // Test byte; shares the access rules of the power control group
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scratch <= UPR_SCRATCH_RESET;
    end else if (scr_hit) begin
      scratch <= upr_apply(scratch, bus.op, bus.wdata);
    end
  end

  // Read data holds until the next read; refused addresses read as zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= UPR_RDATA_NONE;
    end else if (bus.req && bus.op == UPR_OP_READ) begin
      if (pwr_rd) begin
        rdata_q <= power_control;
      end else if (scr_rd) begin
        rdata_q <= scratch;
      end else begin
        rdata_q <= UPR_RDATA_NONE;
      end
    end
  end

  // One acknowledge per request, one cycle later
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.ack <= 1'b0;
    end else begin
      bus.ack <= bus.req;
    end
  end

  assign bus.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // BVALID edge notification
  // Sampled copy resets low, the comparator's idle level, so no false edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
    end else begin
      bvalid_q <= bvalid_i;
    end
  end

  always_comb begin
    bvalid_rise = !bvalid_q && bvalid_i;
    bvalid_fall = bvalid_q && !bvalid_i;
    notify      = (power_control[UPR_BIT_BV_FALL] && bvalid_fall) ||
                  (power_control[UPR_BIT_BV_RISE] && bvalid_rise);
  end

  // One flag pulse per enabled edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_flag_q <= 1'b0;
    end else begin
      alt_flag_q <= notify;
    end
  end

  assign bus.alternate_interrupt_flag = alt_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin role
  always_comb begin
    pin_oe_o    = power_control[UPR_BIT_PIN_SEL];
    pin_o       = !power_on_i;
    pin_reset_o = !power_control[UPR_BIT_PIN_SEL] && !pin_i;
  end

  assign power_control_o = power_control;
endmodule
`default_nettype wire

/* verilog/upr_link.sv */
`timescale 1ns/1ps
`default_nettype none
module upr_link (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  upr_if.link                      bus,
  input  wire logic                cmd_valid_i,
  input  wire upr_pkg::upr_op_e    cmd_op_i,
  input  wire logic                cmd_ext_i,
  input  wire logic [7:0]          cmd_addr_i,
  input  wire logic [7:0]          cmd_data_i,
  input  wire logic                ganged_i,
  output logic                     cmd_ready_o,
  output logic                     cmd_done_o,
  output logic [7:0]               cmd_rdata_o,
  output logic                     alt_event_o
);
  import upr_pkg::*;

  logic       busy;
  logic [7:0] data_fix;
  logic       bad_ext;

  // Reserved bits forced low at vendor addresses; ganged power forces pin select high on writes
  always_comb begin
    data_fix = cmd_data_i & ~UPR_PWR_RSVD_MASK;
    if (ganged_i && cmd_op_i == UPR_OP_WRITE && cmd_addr_i[5:0] == UPR_PWR_WRITE) begin
      data_fix[UPR_BIT_PIN_SEL] = 1'b1;
    end
    // A clear must not drop the pin select while power is ganged
    if (ganged_i && cmd_op_i == UPR_OP_CLEAR && cmd_addr_i[5:0] == UPR_PWR_CLEAR) begin
      data_fix[UPR_BIT_PIN_SEL] = 1'b0;
    end
    if (cmd_addr_i[5:0] < UPR_VENDOR_FIRST) begin
      data_fix = cmd_data_i;
    end
    bad_ext = cmd_ext_i && (cmd_addr_i > UPR_EXT_LAST);
  end

  assign cmd_ready_o = !busy;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy      <= 1'b0;
      bus.req   <= 1'b0;
      bus.op    <= UPR_OP_READ;
      bus.ext   <= 1'b0;
      bus.addr  <= 8'h00;
      bus.wdata <= 8'h00;
    end else if (!busy && cmd_valid_i && !bad_ext) begin
      busy      <= 1'b1;
      bus.req   <= 1'b1;
      bus.op    <= cmd_op_i;
      bus.ext   <= cmd_ext_i;
      bus.addr  <= cmd_addr_i;
      bus.wdata <= data_fix;
    end else begin
      bus.req <= 1'b0;
      if (bus.ack) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_done_o  <= 1'b0;
      cmd_rdata_o <= 8'h00;
      alt_event_o <= 1'b0;
    end else begin
      cmd_done_o  <= bus.ack || (!busy && cmd_valid_i && bad_ext);
      alt_event_o <= bus.alternate_interrupt_flag;
      if (bus.ack) begin
        cmd_rdata_o <= bus.rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/upr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module upr_props (
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic             req,
  input wire upr_pkg::upr_op_e op,
  input wire logic             ext,
  input wire logic [7:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             ack,
  input wire logic [7:0]       rdata,
  input wire logic             alternate_interrupt_flag
);
  import upr_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] pc;
  wire        hit = req && (!ext || addr <= UPR_EXT_LAST);
  // Shadow of the power control byte, rebuilt from bus traffic
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) pc <= 8'h00;
    else if (hit && op == UPR_OP_WRITE && addr[5:0] == UPR_PWR_WRITE) pc <= wdata;
    else if (hit && op == UPR_OP_SET && addr[5:0] == UPR_PWR_SET) pc <= pc | wdata;
    else if (hit && op == UPR_OP_CLEAR && addr[5:0] == UPR_PWR_CLEAR) pc <= pc & ~wdata;
  end
  ////////////////////////////////////////////////////////////////
  property p_ack; req |=> ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack1; ack |-> $past(req) ##1 !ack; endproperty
  a_ack1: assert property (p_ack1) else $error("stray or long ack");
  property p_esc;
    req && !ext && addr[5:0] == UPR_ADDR_ESCAPE && op == UPR_OP_READ |=> rdata == 8'h00;
  endproperty
  a_esc: assert property (p_esc) else $error("escape address returned data");
  property p_ext; req |-> !(ext && addr > UPR_EXT_LAST); endproperty
  a_ext: assert property (p_ext) else $error("unimplemented extended access");
  property p_read;
    hit && op == UPR_OP_READ && addr[5:0] >= UPR_PWR_WRITE |=> rdata == pc;
  endproperty
  a_read: assert property (p_read) else $error("power control read mismatch");
  property p_rsvd;
    req && op != UPR_OP_READ && addr[5:0] >= UPR_VENDOR_FIRST |-> wdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("ones written to reserved bits");
  property p_alt; alternate_interrupt_flag |-> ($past(pc) & 8'h0c) != 8'h00; endproperty
  a_alt: assert property (p_alt) else $error("notification while disabled");
  property p_alt1; alternate_interrupt_flag |=> !alternate_interrupt_flag; endproperty
  a_alt1: assert property (p_alt1) else $error("notification longer than one cycle");
  c_read: cover property (hit && op == UPR_OP_READ && ext);
  c_alt: cover property (alternate_interrupt_flag);
  c_esc: cover property (req && addr[5:0] == UPR_ADDR_ESCAPE);
endmodule
`default_nettype wire

/* testbench/ulpi_phy_extended_power_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_extended_power_regs_tb;
  import upr_pkg::*;
  logic       sys_clk_i = 1'b0, rst_i = 1'b1, cmd_valid = 1'b0, cmd_ext = 1'b0;
  logic       ganged = 1'b0, bvalid = 1'b0, pin_in = 1'b1, power_on = 1'b0;
  upr_op_e    cmd_op = UPR_OP_READ;
  logic [7:0] cmd_addr = 8'h00, cmd_data = 8'h00, pc_o, rdata, pc, v;
  logic       ready, done, alt_ev, pin_o, pin_oe, pin_rst;
  logic [8:0] expq[$];
  logic [8:0] e;
  int         n_fail = 0, total_checks = 0, n_alt = 0, seed = 32'h5d89;
  always #25 sys_clk_i = ~sys_clk_i;
  upr_if bus_if ();
  upr_phy upr_phy_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_if), .bvalid_i(bvalid),
    .pin_i(pin_in), .power_on_i(power_on), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .pin_reset_o(pin_rst), .power_control_o(pc_o));
  upr_link upr_link_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_if),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_ext_i(cmd_ext), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .ganged_i(ganged), .cmd_ready_o(ready), .cmd_done_o(done),
    .cmd_rdata_o(rdata), .alt_event_o(alt_ev));
  upr_props upr_props_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req(bus_if.req),
    .op(bus_if.op), .ext(bus_if.ext), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .ack(bus_if.ack), .rdata(bus_if.rdata),
    .alternate_interrupt_flag(bus_if.alternate_interrupt_flag));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Issue one command and wait for its completion pulse
  task automatic cmd(input upr_op_e o, input logic x, input logic [7:0] a, d,
                     input logic [8:0] ex);
    int k;
    expq.push_back(ex);
    cmd_op <= o;
    cmd_ext <= x;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge sys_clk_i);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (!done && k < 10);
    chk({7'h00, ready}, 8'h01);
    if (!done) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic bv(input logic b, input logic [7:0] exp);
    bvalid <= b;
    repeat (5) @(posedge sys_clk_i);
    chk(8'(n_alt), exp);
  endtask
  always @(posedge sys_clk_i) if (alt_ev) n_alt++;
  always @(posedge sys_clk_i) if (done) begin
    e = expq.pop_front();
    if (e[8]) chk(rdata, e[7:0]);
  end
  initial begin
    #(3000 * 50);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    pin_in <= 1'b0;
    @(posedge sys_clk_i);
    chk(pc_o, UPR_PWR_RESET);
    chk({7'h00, pin_oe}, 8'h00);
    chk({7'h00, pin_rst}, 8'h01);
    chk({7'h00, ready}, 8'h01);
    pc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      cmd(UPR_OP_WRITE, i[0], 8'h3d, v, 9'h000);
      pc = v & 8'h0f;
      v = 8'($random(seed));
      cmd(UPR_OP_SET, 1'b0, 8'h3e, v, 9'h000);
      pc = pc | (v & 8'h0f);
      v = 8'($random(seed));
      cmd(UPR_OP_CLEAR, i[1], 8'h3f, v, 9'h000);
      pc = pc & ~(v & 8'h0f);
      for (int j = 0; j < 3; j++) cmd(UPR_OP_READ, j[0], 8'(8'h3d + j), 8'h00, {1'b1, pc});
      chk(pc_o, pc);
    end
    cmd(UPR_OP_WRITE, 1'b1, 8'hbd, 8'h05, 9'h000);
    chk(pc_o, pc);
    cmd(UPR_OP_WRITE, 1'b0, 8'h2f, 8'h5a, 9'h000);
    cmd(UPR_OP_READ, 1'b0, 8'h2f, 8'h00, 9'h100);
    cmd(UPR_OP_WRITE, 1'b0, 8'h16, 8'ha5, 9'h000);
    cmd(UPR_OP_READ, 1'b1, 8'h17, 8'h00, 9'h1a5);
    cmd(UPR_OP_WRITE, 1'b0, 8'h3d, 8'h08, 9'h000);
    bv(1'b1, 8'h00);
    bv(1'b0, 8'h01);
    cmd(UPR_OP_WRITE, 1'b0, 8'h3d, 8'h04, 9'h000);
    bv(1'b1, 8'h02);
    bv(1'b0, 8'h02);
    ganged <= 1'b1;
    power_on <= 1'b1;
    cmd(UPR_OP_WRITE, 1'b0, 8'h3d, 8'h00, 9'h000);
    chk(pc_o, 8'h01);
    chk({6'h00, pin_oe, pin_o}, 8'h02);
    chk({7'h00, pin_rst}, 8'h00);
    cmd(UPR_OP_CLEAR, 1'b0, 8'h3f, 8'h01, 9'h000);
    chk(pc_o, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
